/* File: pkg/codec_serial_params.svh */
// register map, field positions and reset values of the codec serial block
`ifndef CODEC_SERIAL_PARAMS_SVH
`define CODEC_SERIAL_PARAMS_SVH
`define CSB_ADDR_W 4
`define CSB_A_CTRL_MAIN 4'h0
`define CSB_A_CTRL_FRAME 4'h1
`define CSB_A_CTRL_CLOCK 4'h2
`define CSB_A_STATUS 4'h3
`define CSB_A_RX_SLOTS 4'h4
`define CSB_A_TX_SLOTS 4'h5
`define CSB_A_TX_BASE 2'h2
`define CSB_A_RX_BASE 2'h3
`define CSB_MASK_MAIN 16'hAFE3
`define CSB_MASK_FRAME 16'h0DEF
`define CSB_MASK_CLOCK 16'h0FFF
`define CSB_RST_REG 16'h0000
`define CSB_B_ON 15
`define CSB_B_SIDL 13
`define CSB_B_LOOP 11
`define CSB_B_BCKD 10
`define CSB_B_BCKE 9
`define CSB_B_FSD 8
`define CSB_B_UNDERFLOW_REPEAT_SEL 7
`define CSB_B_SDOM 6
`define CSB_B_DATA_JUSTIFY 5
`define CSB_B_ROV 3
`define CSB_B_TX_UNDERFLOW_FLAG 1
`define CSB_PROTO_MC 2'h0
`define CSB_PROTO_I2S 2'h1
`define CSB_ACLINK_SYNC_BITS 9'h010
`define CSB_PEND_NONE 2'h0
`define CSB_PEND_AT0 2'h1
`define CSB_PEND_AT1 2'h2
`endif

/* File: pkg/codec_serial_pkg.sv */
// types shared by the codec serial block
package codec_serial_pkg;
  typedef enum logic [1:0] {LS_OFF, LS_WAIT, LS_RUN} linkState_t;
  typedef struct packed {
    logic bclk;
    logic fs;
    logic sdi;
  } linkIn_t;
  typedef struct packed {
    logic bclk;
    logic bclkOeN;
    logic fs;
    logic fsOeN;
    logic sdo;
    logic sdoOeN;
  } linkOut_t;
endpackage

/* File: logic/codec_serial_block.sv */
// framed serial codec interface: registers, bit clock, framing and slot data path
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "codec_serial_params.svh"
// Behaviour
// - word size field gives N+1 bits per word, 4 to 16; codes below 3 invalid
// - long words go as several 16-bit slots in consecutive buffer words
// - at most 16 slots per frame, at most 256 bit periods
// - per-slot bits decide transmit and receive in each slot
// - four transmit and four receive buffer words
// - bit 15 enables the module; while clear no serial transfer
// - stop-when-idle bit halts the block while the cpu idles
// - bit clock direction: set is input, clear is output, when enabled
// - edge select: set drives on falling, samples on rising; clear opposite
// - frame sync direction: set is input slave, clear is output master
// - underflow sends zeros, or repeats last written word when selected
// - disabled transmit slots tri-state or drive zero by output mode bit
// - justify set: data in frame sync cycle; clear: one cycle later
// - protocol field: 00 multi-channel, 01 I2S, 10/11 AC-Link
// - words per interrupt is field plus one, one to four
// - words per frame is field plus one, 1 to 16
// - buffer words reachable by dma over the register port
// - block runs all serial timing, signals only when block complete
// - receive slot enables capture input only in enabled slots
// - transmit slot enables send buffer data only in enabled slots
// - status reports overflow, new data, underflow and transmit empty
// - 12-bit divider sets internal bit clock rate when driving it
module codec_serial_block (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`CSB_ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic cpuIdle,
  input wire codec_serial_pkg::linkIn_t linkIn,
  output codec_serial_pkg::linkOut_t linkOut,
  output logic blockDone
);
  function automatic logic [15:0] wordMask(input logic [3:0] ws);
    wordMask = 16'hFFFF >> (4'hF - ws);
  endfunction
  function automatic logic [8:0] frameLenOf(input logic [3:0] wpf, input logic [3:0] ws);
    logic [17:0] p;
    p = ({5'h00, wpf} + 9'h001) * ({5'h00, ws} + 9'h001);
    frameLenOf = p[8:0];
  endfunction

  // three-stage pin synchronisers
  logic [2:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [2:0] nxt_s1, nxt_s2, nxt_s3, nxt_filt;
  always_comb begin
    logic [2:0] eq;
    eq = 3'h0;
    nxt_s1 = {linkIn.bclk, linkIn.fs, linkIn.sdi};
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    // a change counts only once two stages agree: rejects one-cycle glitches
    eq = ~(s2_ff ^ s3_ff);
    nxt_filt = (eq & s3_ff) | (~eq & filt_ff);
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      s3_ff <= 3'h0;
      filt_ff <= 3'h0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      filt_ff <= nxt_filt;
    end
  end
  logic extBclk, extFs, extSdi;
  assign extBclk = filt_ff[2];
  assign extFs = filt_ff[1];
  assign extSdi = filt_ff[0];

  // core state
  logic [15:0] ctrlMain_ff, ctrlFrame_ff, ctrlClock_ff, rxSlots_ff, txSlots_ff, lastTx_ff, rdata_ff;
  logic [15:0] nxt_ctrlMain, nxt_ctrlFrame, nxt_ctrlClock, nxt_rxSlots, nxt_txSlots, nxt_lastTx, nxt_rdata;
  logic [15:0] txBuf_ff [4];
  logic [15:0] rxBuf_ff [4];
  logic [15:0] nxt_txBuf [4];
  logic [15:0] nxt_rxBuf [4];
  logic [3:0] txValid_ff, nxt_txValid;
  logic rov_ff, tx_underflow_flag_ff, rx_full_flag_ff, rxSeen_ff, nxt_rov, nxt_tx_underflow_flag, nxt_rx_full_flag, nxt_rxSeen;
  logic [11:0] divCnt_ff, nxt_divCnt;
  logic bclkInt_ff, prevClk_ff, lastFs_ff, nxt_bclkInt, nxt_prevClk, nxt_lastFs;
  codec_serial_pkg::linkState_t state_ff, nxt_state;
  logic [8:0] frameBit_ff, nxt_frameBit;
  logic [3:0] bitCnt_ff, slot_ff, nxt_bitCnt, nxt_slot;
  logic [1:0] bufIdx_ff, nxt_bufIdx, pend_ff, nxt_pend;
  logic [15:0] shTx_ff, shRx_ff, nxt_shTx, nxt_shRx;
  logic sdo_ff, sdoOeN_ff, fsOut_ff, done_ff;
  logic nxt_sdo, nxt_sdoOeN, nxt_fsOut, nxt_done;

  logic moduleOn, active, bckd, bcke, fsd, data_justify;
  logic [1:0] proto, words_per_interrupt;
  logic [3:0] wpf, ws;
  logic [8:0] frameLen;
  logic clkSrc, riseEdge, fallEdge, driveEdge, sampleEdge;
  assign moduleOn = ctrlMain_ff[`CSB_B_ON];
  assign active = moduleOn & ~(ctrlMain_ff[`CSB_B_SIDL] & cpuIdle);
  assign bckd = ctrlMain_ff[`CSB_B_BCKD];
  assign bcke = ctrlMain_ff[`CSB_B_BCKE];
  assign fsd = ctrlMain_ff[`CSB_B_FSD];
  assign data_justify = ctrlMain_ff[`CSB_B_DATA_JUSTIFY];
  assign proto = ctrlMain_ff[1:0];
  assign words_per_interrupt = ctrlFrame_ff[11:10];
  assign wpf = ctrlFrame_ff[8:5];
  assign ws = ctrlFrame_ff[3:0];
  assign frameLen = frameLenOf(wpf, ws);
  assign clkSrc = bckd ? extBclk : bclkInt_ff;
  assign riseEdge = clkSrc & ~prevClk_ff;
  assign fallEdge = ~clkSrc & prevClk_ff;
  // edges are ignored once stopped, so a disable never lands mid-update
  assign driveEdge = active & (bcke ? fallEdge : riseEdge);
  assign sampleEdge = active & (bcke ? riseEdge : fallEdge);

  logic startNow, loadNow, txEnNow, underNow;
  always_comb begin
    logic [3:0] slotN;
    logic [15:0] word, rxWord;
    logic [8:0] nfb;
    logic rxBit;
    slotN = slot_ff;
    word = 16'h0000;
    rxWord = 16'h0000;
    nfb = frameBit_ff;
    rxBit = 1'b0;
    startNow = 1'b0;
    loadNow = 1'b0;
    txEnNow = 1'b0;
    underNow = 1'b0;
    nxt_ctrlMain = ctrlMain_ff;
    nxt_ctrlFrame = ctrlFrame_ff;
    nxt_ctrlClock = ctrlClock_ff;
    nxt_rxSlots = rxSlots_ff;
    nxt_txSlots = txSlots_ff;
    nxt_lastTx = lastTx_ff;
    nxt_txBuf = txBuf_ff;
    nxt_rxBuf = rxBuf_ff;
    nxt_txValid = txValid_ff;
    nxt_rov = rov_ff;
    nxt_tx_underflow_flag = tx_underflow_flag_ff;
    nxt_rx_full_flag = rx_full_flag_ff;
    nxt_rxSeen = rxSeen_ff;
    nxt_divCnt = divCnt_ff;
    nxt_bclkInt = bclkInt_ff;
    nxt_prevClk = clkSrc;
    nxt_lastFs = lastFs_ff;
    nxt_state = state_ff;
    nxt_frameBit = frameBit_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_slot = slot_ff;
    nxt_bufIdx = bufIdx_ff;
    nxt_pend = pend_ff;
    nxt_shTx = shTx_ff;
    nxt_shRx = shRx_ff;
    nxt_sdo = sdo_ff;
    nxt_sdoOeN = sdoOeN_ff;
    nxt_fsOut = fsOut_ff;
    nxt_done = 1'b0;
    // software clears first, so hardware sets below win
    if (regWr) begin
      case (regAddr)
        `CSB_A_CTRL_MAIN: nxt_ctrlMain = regWdata & `CSB_MASK_MAIN;
        `CSB_A_CTRL_FRAME: nxt_ctrlFrame = regWdata & `CSB_MASK_FRAME;
        `CSB_A_CTRL_CLOCK: nxt_ctrlClock = regWdata & `CSB_MASK_CLOCK;
        `CSB_A_RX_SLOTS: nxt_rxSlots = regWdata;
        `CSB_A_TX_SLOTS: nxt_txSlots = regWdata;
        `CSB_A_STATUS: begin
          if (regWdata[`CSB_B_ROV]) nxt_rov = 1'b0;
          if (regWdata[`CSB_B_TX_UNDERFLOW_FLAG]) nxt_tx_underflow_flag = 1'b0;
        end
        default: ;
      endcase
    end
    if (regRd && regAddr[3:2] == `CSB_A_RX_BASE) nxt_rx_full_flag = 1'b0;
    // internal bit clock: half period is divider value plus one
    if (active && !bckd) begin
      if (divCnt_ff >= ctrlClock_ff[11:0]) begin
        nxt_divCnt = 12'h000;
        nxt_bclkInt = ~bclkInt_ff;
      end else begin
        nxt_divCnt = divCnt_ff + 12'h001;
      end
    end else begin
      nxt_divCnt = 12'h000;
      nxt_bclkInt = 1'b0;
    end
    case (state_ff)
      codec_serial_pkg::LS_OFF: begin
        nxt_sdoOeN = 1'b1;
        nxt_fsOut = 1'b0;
        nxt_pend = `CSB_PEND_NONE;
        nxt_frameBit = 9'h1FF;
        if (active) nxt_state = codec_serial_pkg::LS_WAIT;
      end
      codec_serial_pkg::LS_WAIT, codec_serial_pkg::LS_RUN: begin
        if (sampleEdge) begin
          nxt_lastFs = extFs;
          // slave frame start is the sampled rising edge of the sync pin
          if (fsd && extFs && !lastFs_ff)
            nxt_pend = data_justify ? `CSB_PEND_AT1 : `CSB_PEND_AT0;
          if (state_ff == codec_serial_pkg::LS_RUN) begin
            rxBit = ctrlMain_ff[`CSB_B_LOOP] ? sdo_ff : extSdi;
            rxWord = {shRx_ff[14:0], rxBit};
            nxt_shRx = rxWord;
            if (bitCnt_ff == ws) begin
              if (rxSlots_ff[slot_ff]) begin
                nxt_rxBuf[bufIdx_ff] = rxWord & wordMask(ws);
                nxt_rxSeen = 1'b1;
                if (rx_full_flag_ff) nxt_rov = 1'b1;
              end
              // each used slot takes the next buffer word, so long words land in sequence
              if (rxSlots_ff[slot_ff] || txSlots_ff[slot_ff]) begin
                if (bufIdx_ff == words_per_interrupt) begin
                  nxt_bufIdx = 2'h0;
                  nxt_done = 1'b1;
                  nxt_rxSeen = 1'b0;
                  if (rxSeen_ff || rxSlots_ff[slot_ff]) nxt_rx_full_flag = 1'b1;
                end else begin
                  nxt_bufIdx = bufIdx_ff + 2'h1;
                end
              end
            end
          end
        end
        if (driveEdge) begin
          if (!fsd) begin
            nfb = (frameBit_ff >= frameLen - 9'h001) ? 9'h000 : frameBit_ff + 9'h001;
            nxt_frameBit = nfb;
            startNow = (nfb == 9'h000);
            case (proto)
              `CSB_PROTO_MC: nxt_fsOut = data_justify ? (nfb == 9'h000) : (nfb == frameLen - 9'h001);
              `CSB_PROTO_I2S: nxt_fsOut = (nfb >= {1'b0, frameLen[8:1]});
              default: nxt_fsOut = (nfb < `CSB_ACLINK_SYNC_BITS);
            endcase
          end else begin
            startNow = (pend_ff != `CSB_PEND_NONE);
            nxt_pend = `CSB_PEND_NONE;
          end
          if (startNow) begin
            nxt_state = codec_serial_pkg::LS_RUN;
            // a late slave sync already spent bit 0 of the word
            nxt_bitCnt = (fsd && pend_ff == `CSB_PEND_AT1) ? 4'h1 : 4'h0;
            nxt_slot = 4'h0;
            slotN = 4'h0;
            loadNow = 1'b1;
          end else if (state_ff == codec_serial_pkg::LS_RUN) begin
            if (bitCnt_ff == ws) begin
              nxt_bitCnt = 4'h0;
              slotN = (slot_ff >= wpf) ? 4'h0 : slot_ff + 4'h1;
              nxt_slot = slotN;
              loadNow = 1'b1;
            end else begin
              nxt_bitCnt = bitCnt_ff + 4'h1;
              nxt_shTx = {shTx_ff[14:0], 1'b0};
            end
          end
          txEnNow = txSlots_ff[slotN];
          if (loadNow) begin
            if (txEnNow) begin
              underNow = ~txValid_ff[bufIdx_ff];
              word = txValid_ff[bufIdx_ff] ? txBuf_ff[bufIdx_ff]
                   : (ctrlMain_ff[`CSB_B_UNDERFLOW_REPEAT_SEL] ? lastTx_ff : 16'h0000);
              nxt_txValid[bufIdx_ff] = 1'b0;
              if (underNow) nxt_tx_underflow_flag = 1'b1;
            end
            nxt_shTx = (word << (4'hF - ws));
            if (fsd && startNow && pend_ff == `CSB_PEND_AT1) nxt_shTx = (word << (4'hF - ws)) << 1;
          end
          if (startNow || state_ff == codec_serial_pkg::LS_RUN) begin
            nxt_sdo = txEnNow ? nxt_shTx[15] : 1'b0;
            nxt_sdoOeN = txEnNow ? 1'b0 : ctrlMain_ff[`CSB_B_SDOM];
          end
        end
        if (!active) begin
          // release the pins at once rather than after one more bit
          nxt_state = codec_serial_pkg::LS_OFF;
          nxt_sdoOeN = 1'b1;
          nxt_fsOut = 1'b0;
        end
      end
      default: nxt_state = codec_serial_pkg::LS_OFF;
    endcase
    // writes after the link so a new word is never lost to a same-cycle load
    if (regWr && regAddr[3:2] == `CSB_A_TX_BASE) begin
      nxt_txBuf[regAddr[1:0]] = regWdata;
      nxt_txValid[regAddr[1:0]] = 1'b1;
      nxt_lastTx = regWdata;
    end
    nxt_rdata = 16'h0000;
    if (regRd) begin
      case (regAddr[3:2])
        `CSB_A_TX_BASE: nxt_rdata = txBuf_ff[regAddr[1:0]];
        `CSB_A_RX_BASE: nxt_rdata = rxBuf_ff[regAddr[1:0]];
        default: begin
          case (regAddr)
            `CSB_A_CTRL_MAIN: nxt_rdata = ctrlMain_ff;
            `CSB_A_CTRL_FRAME: nxt_rdata = ctrlFrame_ff;
            `CSB_A_CTRL_CLOCK: nxt_rdata = ctrlClock_ff;
            `CSB_A_STATUS: nxt_rdata = {4'h0, slot_ff, 4'h0, rov_ff, rx_full_flag_ff, tx_underflow_flag_ff, ~|txValid_ff};
            `CSB_A_RX_SLOTS: nxt_rdata = rxSlots_ff;
            `CSB_A_TX_SLOTS: nxt_rdata = txSlots_ff;
            default: nxt_rdata = 16'h0000;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrlMain_ff <= `CSB_RST_REG;
      ctrlFrame_ff <= `CSB_RST_REG;
      ctrlClock_ff <= `CSB_RST_REG;
      rxSlots_ff <= `CSB_RST_REG;
      txSlots_ff <= `CSB_RST_REG;
      lastTx_ff <= `CSB_RST_REG;
      rdata_ff <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        txBuf_ff[i] <= 16'h0000;
        rxBuf_ff[i] <= 16'h0000;
      end
      txValid_ff <= 4'h0;
      rov_ff <= 1'b0;
      tx_underflow_flag_ff <= 1'b0;
      rx_full_flag_ff <= 1'b0;
      rxSeen_ff <= 1'b0;
      divCnt_ff <= 12'h000;
      bclkInt_ff <= 1'b0;
      prevClk_ff <= 1'b0;
      lastFs_ff <= 1'b0;
      state_ff <= codec_serial_pkg::LS_OFF;
      frameBit_ff <= 9'h1FF;
      bitCnt_ff <= 4'h0;
      slot_ff <= 4'h0;
      bufIdx_ff <= 2'h0;
      pend_ff <= 2'h0;
      shTx_ff <= 16'h0000;
      shRx_ff <= 16'h0000;
      sdo_ff <= 1'b0;
      sdoOeN_ff <= 1'b1;
      fsOut_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      ctrlMain_ff <= nxt_ctrlMain;
      ctrlFrame_ff <= nxt_ctrlFrame;
      ctrlClock_ff <= nxt_ctrlClock;
      rxSlots_ff <= nxt_rxSlots;
      txSlots_ff <= nxt_txSlots;
      lastTx_ff <= nxt_lastTx;
      rdata_ff <= nxt_rdata;
      txBuf_ff <= nxt_txBuf;
      rxBuf_ff <= nxt_rxBuf;
      txValid_ff <= nxt_txValid;
      rov_ff <= nxt_rov;
      tx_underflow_flag_ff <= nxt_tx_underflow_flag;
      rx_full_flag_ff <= nxt_rx_full_flag;
      rxSeen_ff <= nxt_rxSeen;
      divCnt_ff <= nxt_divCnt;
      bclkInt_ff <= nxt_bclkInt;
      prevClk_ff <= nxt_prevClk;
      lastFs_ff <= nxt_lastFs;
      state_ff <= nxt_state;
      frameBit_ff <= nxt_frameBit;
      bitCnt_ff <= nxt_bitCnt;
      slot_ff <= nxt_slot;
      bufIdx_ff <= nxt_bufIdx;
      pend_ff <= nxt_pend;
      shTx_ff <= nxt_shTx;
      shRx_ff <= nxt_shRx;
      sdo_ff <= nxt_sdo;
      sdoOeN_ff <= nxt_sdoOeN;
      fsOut_ff <= nxt_fsOut;
      done_ff <= nxt_done;
    end
  end

  assign regRdata = rdata_ff;
  assign blockDone = done_ff;
  assign linkOut.bclk = bclkInt_ff;
  assign linkOut.bclkOeN = ~(moduleOn & ~bckd);
  assign linkOut.fs = fsOut_ff;
  assign linkOut.fsOeN = ~(moduleOn & ~fsd);
  assign linkOut.sdo = sdo_ff;
  assign linkOut.sdoOeN = sdoOeN_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_WORD_BITS: assert property (state_ff == codec_serial_pkg::LS_RUN && !driveEdge |-> bitCnt_ff <= ws)
    else $error("bit counter ran past word size");
  AST_OFF_RELEASE: assert property (!moduleOn |=> linkOut.sdoOeN && state_ff == codec_serial_pkg::LS_OFF)
    else $error("disabled block still drives data");
  AST_IDLE_HALT: assert property (moduleOn && ctrlMain_ff[`CSB_B_SIDL] && cpuIdle
    |=> state_ff == codec_serial_pkg::LS_OFF)
    else $error("block ran during cpu idle");
  AST_DIV_TOGGLE: assert property (active && !bckd && divCnt_ff >= ctrlClock_ff[11:0] |=> bclkInt_ff != $past(bclkInt_ff))
    else $error("internal bit clock missed its toggle");
  AST_UNDERFLOW_ZERO: assert property (loadNow && underNow && !ctrlMain_ff[`CSB_B_UNDERFLOW_REPEAT_SEL] |=> shTx_ff == 16'h0000 && tx_underflow_flag_ff)
    else $error("underflow did not send zeros");
  AST_IDLE_SLOT_OUT: assert property (driveEdge && state_ff == codec_serial_pkg::LS_RUN && !txEnNow
    |=> sdoOeN_ff == $past(ctrlMain_ff[`CSB_B_SDOM]) && !sdo_ff)
    else $error("disabled slot output wrong");
  AST_FRAME_RESTART: assert property (driveEdge && startNow |=> slot_ff == 4'h0 && state_ff == codec_serial_pkg::LS_RUN)
    else $error("slot counter did not restart");
  AST_SLOT_WRAP: assert property (state_ff == codec_serial_pkg::LS_RUN && $changed(slot_ff)
    |-> slot_ff == 4'h0 || slot_ff == $past(slot_ff) + 4'h1)
    else $error("slot counter skipped");
  AST_BLOCK_DONE: assert property (done_ff |-> bufIdx_ff == 2'h0 && $past(bufIdx_ff) == $past(words_per_interrupt))
    else $error("block done at wrong word count");
  AST_OVERFLOW: assert property (sampleEdge && state_ff == codec_serial_pkg::LS_RUN && bitCnt_ff == ws
    && rxSlots_ff[slot_ff] && rx_full_flag_ff |=> rov_ff)
    else $error("overflow not flagged");
  COV_BLOCK: cover property (done_ff);
  COV_UNDER: cover property ($rose(tx_underflow_flag_ff));
  COV_OVER: cover property ($rose(rov_ff));
  COV_SLAVE_START: cover property (fsd && driveEdge && startNow);
endmodule
`default_nettype wire

/* File: tb/codec_model.sv */
// behavioural codec at the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  input wire logic drive,
  input wire logic edgeSel,
  input wire codec_serial_pkg::linkOut_t linkOut,
  output wire codec_serial_pkg::linkIn_t linkIn,
  output logic [15:0] captWord
);
  logic mClk = 1'b0;
  logic mFs = 1'b0;
  logic mSdi = 1'b0;
  // released pins fall to the pull-down level
  assign linkIn.bclk = linkOut.bclkOeN ? (drive & mClk) : linkOut.bclk;
  assign linkIn.fs = linkOut.fsOeN ? (drive & mFs) : linkOut.fs;
  assign linkIn.sdi = mSdi;
  // sample on the edge opposite the drive edge
  always @(linkIn.bclk) begin
    if (linkIn.bclk === edgeSel) begin
      captWord <= {captWord[14:0], linkOut.sdo};
    end
  end
  // master frame: sync bit, data from the next bit, clock still afterwards
  task automatic sendFrame(input logic [15:0] w);
    int i;
    for (i = 0; i < 20; i++) begin
      mFs = (i == 0);
      // outside the word the line toggles, never a held value
      mSdi = (i > 0 && i < 17) ? w[16-i] : ~mSdi;
      #62.5 mClk = 1'b1;
      #62.5 mClk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the codec serial block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic cpuIdle = 1'b0;
  logic drive = 1'b0;
  logic edgeSel = 1'b0;
  logic [15:0] regRdata, captWord, v, d;
  logic blockDone;
  wire codec_serial_pkg::linkIn_t linkIn;
  codec_serial_pkg::linkOut_t linkOut;
  int fails = 0;
  int comparisons = 0;
  int i, n;
  always #4 sys_clk = ~sys_clk;
  codec_serial_block dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuIdle(cpuIdle), .linkIn(linkIn),
    .linkOut(linkOut), .blockDone(blockDone));
  codec_model codec (.drive(drive), .edgeSel(edgeSel), .linkOut(linkOut), .linkIn(linkIn),
    .captWord(captWord));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] underWord(input logic rep, input logic [15:0] last);
    return rep ? last : 16'h0000;
  endfunction
  function automatic logic [15:0] frameCycles(input int words, input int bits, input int div);
    return 16'(words * bits * 2 * (div + 1));
  endfunction
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    r = regRdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] r;
    rd(a, r);
    chk("regRdata", e, r);
  endtask
  task automatic waitDone(input int lim);
    int k;
    k = 0;
    tick(1);
    while (blockDone !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    if (k >= lim) begin
      fails++;
      $display("unexpected blockDone expected 1 seen 0");
      summarize();
    end
  endtask
  // cycles between two frame sync rises; the first rise only arms
  task automatic fsGap(output int g);
    int k, r0, r1;
    logic p;
    r0 = -1;
    r1 = -1;
    p = 1'b1;
    for (k = 0; k < 300; k++) begin
      tick(1);
      if (linkOut.fs === 1'b1 && p === 1'b0 && r0 >= 0 && r1 < 0) r1 = k;
      if (linkOut.fs === 1'b1 && p === 1'b0 && r0 < 0) r0 = k;
      p = linkOut.fs;
    end
    g = r1 - r0;
  endtask
  // bit0: output driven seen, bit1: a one driven seen
  task automatic sdoWatch(output logic [15:0] r);
    r = 16'h0000;
    repeat (200) begin
      tick(1);
      if (linkOut.sdoOeN === 1'b0) r[0] = 1'b1;
      if (linkOut.sdoOeN === 1'b0 && linkOut.sdo !== 1'b0) r[1] = 1'b1;
    end
  endtask
  initial begin
    v = 16'h003C;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++) rchk(4'(i), (i == 3) ? 16'h0001 : 16'h0000);
    wr(4'h0, 16'h7FFF);
    wr(4'h1, 16'hFFFF);
    wr(4'h2, 16'hFFFF);
    wr(4'h6, 16'hFFFF);
    rchk(4'h0, 16'h2FE3);
    rchk(4'h1, 16'h0DEF);
    rchk(4'h2, 16'h0FFF);
    rchk(4'h6, 16'h0000);
    for (i = 4; i < 12; i++) begin
      if (i == 6 || i == 7) continue;
      v = lfsr(v);
      wr(4'(i), v);
      rchk(4'(i), v);
    end
    rchk(4'h3, 16'h0000);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    rchk(4'h8, 16'h0000);
    $display("test registers done");
    wr(4'h2, 16'h0000);
    wr(4'h1, 16'h002F);
    for (i = 0; i < 4; i++) begin
      wr(4'h0, 16'h8000 | 16'(i));
      fsGap(n);
      chk("fs gap", frameCycles(2, 16, 0), 16'(n));
      chk("master oe", 16'h0000, {14'h0, linkOut.bclkOeN, linkOut.fsOeN});
      wr(4'h0, 16'h0000);
      tick(3);
      chk("off pins", 16'h000D, {12'h0, linkOut.bclkOeN, linkOut.fsOeN, linkOut.fs, linkOut.sdoOeN});
    end
    $display("test protocols done");
    wr(4'h2, 16'h0003);
    wr(4'h1, 16'h000F);
    wr(4'h4, 16'h0001);
    wr(4'h5, 16'h0001);
    for (i = 0; i < 2; i++) begin
      v = lfsr(v);
      edgeSel <= i[0];
      wr(4'h8, v);
      wr(4'h0, 16'h8820 | (16'(i) << 9) | (16'(i) << 7));
      waitDone(300);
      chk("sdo word", v, captWord);
      rd(4'h3, d);
      chk("rx full", 16'h0004, d & 16'h0004);
      rchk(4'hC, v);
      waitDone(300);
      chk("underflow word", underWord(i[0], v), captWord);
      rd(4'h3, d);
      chk("underflow flag", 16'h0002, d & 16'h0002);
      wr(4'h0, 16'h0000);
    end
    $display("test loopback done");
    wr(4'h5, 16'h0000);
    for (i = 0; i < 2; i++) begin
      wr(4'h0, 16'h8000 | (16'(i) << 6));
      sdoWatch(d);
      chk("idle slot sdo", i[0] ? 16'h0000 : 16'h0001, d);
      wr(4'h0, 16'h0000);
    end
    $display("test idle slots done");
    cpuIdle <= 1'b1;
    wr(4'h0, 16'hA800);
    n = 0;
    repeat (300) begin
      tick(1);
      if (blockDone === 1'b1) n++;
    end
    chk("done while idle", 16'h0000, 16'(n));
    cpuIdle <= 1'b0;
    waitDone(300);
    wr(4'h0, 16'h0000);
    $display("test idle stop done");
    drive <= 1'b1;
    edgeSel <= 1'b1;
    wr(4'h0, 16'h8700);
    v = lfsr(v);
    tick(2);
    chk("slave oe", 16'h0003, {14'h0, linkOut.bclkOeN, linkOut.fsOeN});
    fork
      codec.sendFrame(v);
      waitDone(400);
    join
    rchk(4'hC, v);
    wr(4'h4, 16'h0000);
    codec.sendFrame(~v);
    rchk(4'hC, v);
    $display("test slave done");
    summarize();
  end
endmodule
`default_nettype wire
